// ===== core/sol_params.svh
// constants for the system option latches: bus offsets, reset values, counts
// assumes a 32-bit AHB-Lite slave with one register per aligned word
`ifndef SOL_PARAMS_SVH
`define SOL_PARAMS_SVH

// register indices as printed; the byte address is four times the index
`define SOL_IDX_LATCH_A 8'h1d
`define SOL_IDX_LATCH_B 8'h1f
`define SOL_ADDR_LATCH_A 10'h074
`define SOL_ADDR_LATCH_B 10'h07c
// lock status word, read only
`define SOL_ADDR_LOCK_STAT 10'h080

`define SOL_LATCH_A_RESET 8'h00
`define SOL_LATCH_B_RESET 8'h00

// watchdog periods in internal oscillator cycles
`define SOL_WDOG_SHORT 18'd8176
`define SOL_WDOG_LONG 18'd262128
// wake-up delays in internal oscillator cycles
`define SOL_WAKE_SHORT 13'd32
`define SOL_WAKE_LONG 13'd4096

// timebase source codes
`define SOL_TB_INTERNAL 2'h0
`define SOL_TB_RC 2'h1
`define SOL_TB_CRYSTAL 2'h2
`define SOL_TB_UNUSED 2'h3

`endif

// ===== core/sol_pkg.sv
// types for the system option latches
// assumes the constants header is included by the design file
package sol_pkg;

  typedef struct packed {
    logic watchdog_rate_select;
    logic monitor_in_sleep_enable;
    logic monitor_reset_disable;
    logic main_supply_monitor_disable;
    logic regulator_monitor_disable;
    logic short_wake_recovery;
    logic sleep_instr_enable;
    logic watchdog_disable;
  } sol_latch_a_s;

  typedef struct packed {
    logic internal_osc_sleep_disable;
    logic rc_osc_sleep_enable;
    logic crystal_osc_sleep_enable;
    logic timebase_source_hi;
    logic timebase_source_lo;
    logic [1:0] spare;
    logic serial_port_clock_select;
  } sol_latch_b_s;

  // one captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
  } sol_bus_phase_s;

  // oscillators that keep running while the device sleeps
  typedef struct packed {
    logic internal_osc;
    logic rc_osc;
    logic crystal_osc;
  } sol_osc_run_s;

endpackage : sol_pkg

// ===== core/sol_option_latches.sv
// system option latches: two write-once 8-bit option registers on AHB-Lite
// assumes one bus clock, asynchronous active-low reset, single-word transfers;
// the supply monitor reset request arrives asynchronously and is synchronised
//
// Function
// - each option register takes only the first software write after reset.
// - reset forces every bit of both option registers to zero.
// - reads return current contents at any time, locked or not.
// - watchdog period is 8176 cycles with rate select set, else 262128.
// - monitor keeps running in stop only if sleep bit set and a circuit enabled.
// - monitor reset disable blocks the monitor reset, else it passes through.
// - each supply monitor disable bit turns off its own low-voltage circuit.
// - wake-up takes 32 cycles with short recovery set, else 4096.
// - leaving stop through the reset pin always uses the long recovery.
// - stop instruction executes when enabled, else is an illegal opcode.
// - watchdog disable bit set turns the watchdog off, clear turns it on.
// - internal oscillator stops in sleep when its sleep disable bit is set.
// - rc oscillator keeps running in sleep when its enable bit is set.
// - crystal oscillator keeps running in sleep when its enable bit is set.
// - timebase source field selects internal, rc or crystal; code 11 unused.
// - serial port clock select set picks bus clock, clear the oscillator clock.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sol_params.svh"

module sol_option_latches
  import sol_pkg::*;
(
  input wire logic hclk, // bus clock, 20 MHz
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic hready, // bus ready in
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic stop_mode, // device is in stop mode
  input wire logic stop_opcode, // stop instruction decoded, one-cycle pulse
  input wire logic wake_by_reset_pin, // stop is being left through the reset pin
  input wire logic monitor_reset_request, // raw reset request from the supply monitor
  output logic watchdog_enable, // watchdog runs
  output logic [17:0] watchdog_period, // watchdog timeout in oscillator cycles
  output logic main_supply_monitor_on, // main-supply low-voltage circuit powered
  output logic regulator_monitor_on, // regulated-supply low-voltage circuit powered
  output logic monitor_reset, // monitor reset passed to the system reset
  output logic [12:0] wake_delay, // stop recovery in oscillator cycles
  output logic stop_accept, // stop instruction executes, pulse
  output logic illegal_opcode, // stop instruction refused, pulse
  output sol_osc_run_s osc_sleep_run, // oscillators kept alive in stop
  output logic [1:0] timebase_source_clock, // timebase clock select
  output logic serial_port_clock_select // serial port from bus clock when high
);

  sol_latch_a_s latch_a;
  sol_latch_b_s latch_b;
  logic lock_a;
  logic lock_b;
  sol_bus_phase_s phase;
  logic mon_req_meta;
  logic mon_req_sync;
  logic take_phase;
  logic wr_a;
  logic wr_b;
  logic [31:0] next_hrdata;
  logic [9:0] addr_now;
  logic any_monitor_on;

  // byte-address decode, shared by the read path and the write path
  function automatic logic [1:0] sol_decode(input logic [9:0] a);
    sol_decode = 2'b00;
    if (a == `SOL_ADDR_LATCH_A)
      sol_decode = 2'b01;
    else if (a == `SOL_ADDR_LATCH_B)
      sol_decode = 2'b10;
    else if (a == `SOL_ADDR_LOCK_STAT)
      sol_decode = 2'b11;
  endfunction : sol_decode

  // upper address bits must be zero, so the page is not aliased
  function automatic logic sol_in_page(input logic [31:0] a);
    sol_in_page = (a[31:10] == 22'h000000);
  endfunction : sol_in_page

  // register b stores no spare bits, so they always read back as zero
  function automatic sol_latch_b_s sol_pack_b(input logic [7:0] d);
    sol_pack_b = {d[7:3], 2'b00, d[0]};
  endfunction : sol_pack_b

  // a circuit stays powered unless disabled; in stop it also needs the sleep bit
  function automatic logic sol_monitor_power(input logic circuit_disable, input logic in_stop,
    input logic sleep_enable, input logic any_on);
    sol_monitor_power = !circuit_disable && (!in_stop || (sleep_enable && any_on));
  endfunction : sol_monitor_power

  assign take_phase = hsel && htrans[1] && hready;
  assign addr_now = haddr[9:0];

  // a write lands in its data phase, only while the register is unlocked
  assign wr_a = phase.valid && phase.write && (sol_decode(phase.addr) == 2'b01) && !lock_a;
  assign wr_b = phase.valid && phase.write && (sol_decode(phase.addr) == 2'b10) && !lock_b;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase <= '0;
    else if (hready)
    begin
      phase.valid <= take_phase && sol_in_page(haddr);
      phase.write <= hwrite;
      phase.addr <= addr_now;
    end
  end

  // option register a
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_a <= `SOL_LATCH_A_RESET;
      lock_a <= 1'b0;
    end
    else if (wr_a)
    begin
      latch_a <= hwdata[7:0];
      lock_a <= 1'b1;
    end
  end

  // option register b; the two spare bits are not stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_b <= `SOL_LATCH_B_RESET;
      lock_b <= 1'b0;
    end
    else if (wr_b)
    begin
      latch_b <= sol_pack_b(hwdata[7:0]);
      lock_b <= 1'b1;
    end
  end

  // read data is prepared in the address phase so it stands in the data phase;
  // a write still in its data phase is forwarded so a read right behind it sees it
  always_comb
  begin
    next_hrdata = 32'h00000000;
    case (sol_decode(addr_now))
      2'b01:
        next_hrdata[7:0] = wr_a ? hwdata[7:0] : latch_a;
      2'b10:
        next_hrdata[7:0] = wr_b ? sol_pack_b(hwdata[7:0]) : latch_b;
      2'b11:
        next_hrdata[1:0] = {lock_b | wr_b, lock_a | wr_a};
      default:
        next_hrdata = 32'h00000000;
    endcase
    if (!sol_in_page(haddr))
      next_hrdata = 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (take_phase && !hwrite)
      hrdata <= next_hrdata;
  end

  // zero-wait slave: never stalls, never errors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // the monitor request comes from analog logic with no relation to hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mon_req_meta <= 1'b0;
      mon_req_sync <= 1'b0;
    end
    else
    begin
      mon_req_meta <= monitor_reset_request;
      mon_req_sync <= mon_req_meta;
    end
  end

  // watchdog controls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      watchdog_enable <= 1'b0;
      watchdog_period <= `SOL_WDOG_LONG;
    end
    else
    begin
      watchdog_enable <= !latch_a.watchdog_disable;
      watchdog_period <= latch_a.watchdog_rate_select ? `SOL_WDOG_SHORT : `SOL_WDOG_LONG;
    end
  end

  assign any_monitor_on = !latch_a.main_supply_monitor_disable || !latch_a.regulator_monitor_disable;

  // supply monitor power; in stop the circuits stay up only on request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_supply_monitor_on <= 1'b0;
      regulator_monitor_on <= 1'b0;
    end
    else
    begin
      main_supply_monitor_on <= sol_monitor_power(latch_a.main_supply_monitor_disable, stop_mode,
        latch_a.monitor_in_sleep_enable, any_monitor_on);
      regulator_monitor_on <= sol_monitor_power(latch_a.regulator_monitor_disable, stop_mode,
        latch_a.monitor_in_sleep_enable, any_monitor_on);
    end
  end

  // monitor reset gate; software must block this before stop if the monitor will be off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      monitor_reset <= 1'b0;
    else
      monitor_reset <= mon_req_sync && !latch_a.monitor_reset_disable;
  end

  // stop recovery; the short delay undercuts the monitor turn-on time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wake_delay <= `SOL_WAKE_LONG;
    else if (wake_by_reset_pin)
      wake_delay <= `SOL_WAKE_LONG;
    else
      wake_delay <= latch_a.short_wake_recovery ? `SOL_WAKE_SHORT : `SOL_WAKE_LONG;
  end

  // stop instruction gating, one pulse per decoded instruction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stop_accept <= 1'b0;
      illegal_opcode <= 1'b0;
    end
    else
    begin
      stop_accept <= stop_opcode && latch_a.sleep_instr_enable;
      illegal_opcode <= stop_opcode && !latch_a.sleep_instr_enable;
    end
  end

  // oscillators kept alive in stop; the oscillators themselves sit elsewhere
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      osc_sleep_run <= '0;
    else
    begin
      osc_sleep_run.internal_osc <= !latch_b.internal_osc_sleep_disable;
      osc_sleep_run.rc_osc <= latch_b.rc_osc_sleep_enable;
      osc_sleep_run.crystal_osc <= latch_b.crystal_osc_sleep_enable;
    end
  end

  // timebase clock select; code 11 is passed on and left to the mux to ignore
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timebase_source_clock <= `SOL_TB_INTERNAL;
    else
      timebase_source_clock <= {latch_b.timebase_source_hi, latch_b.timebase_source_lo};
  end

  // serial port clock select; the glitch-free switch belongs to the clock mux
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      serial_port_clock_select <= 1'b0;
    else
      serial_port_clock_select <= latch_b.serial_port_clock_select;
  end

endmodule : sol_option_latches

`default_nettype wire

// ===== testbench/sol_latches_assertions.sv
// checker for the option latches: bus answers and derived outputs
// assumes it is bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "sol_params.svh"
module sol_latch_checker (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic stop_opcode, // stop decoded
  input wire logic wake_by_reset_pin, // exit by pin
  input wire logic monitor_reset_request, // raw request
  input wire logic [17:0] watchdog_period, // period
  input wire logic monitor_reset, // reset out
  input wire logic [12:0] wake_delay, // recovery
  input wire logic stop_accept, // stop runs
  input wire logic illegal_opcode // stop refused
);
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_stop_one_answer: assert property (stop_opcode |=> stop_accept != illegal_opcode)
    else $error("stop instruction not answered once");
  a_stop_has_cause: assert property ((stop_accept || illegal_opcode) |-> $past(stop_opcode))
    else $error("stop answer without instruction");
  a_period_two_values: assert property (watchdog_period == `SOL_WDOG_SHORT || watchdog_period == `SOL_WDOG_LONG)
    else $error("watchdog period out of range");
  a_wake_two_values: assert property (wake_delay == `SOL_WAKE_SHORT || wake_delay == `SOL_WAKE_LONG)
    else $error("wake delay out of range");
  a_pin_long_wake: assert property (wake_by_reset_pin && $past(wake_by_reset_pin) |-> wake_delay == `SOL_WAKE_LONG)
    else $error("pin exit not long");
  a_monitor_sync_gate: assert property (monitor_reset |-> $past(monitor_reset_request, 3))
    else $error("monitor reset without request");
  a_unmapped_read_zero: assert property (rd_take && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_data_hold: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved");
  a_lock_word_bits: assert property (rd_take && haddr == 32'h80 |=> hrdata[31:2] == 30'h0)
    else $error("lock word upper bits set");
endmodule : sol_latch_checker

bind sol_option_latches sol_latch_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .stop_opcode(stop_opcode), .wake_by_reset_pin(wake_by_reset_pin), .monitor_reset_request(monitor_reset_request),
  .watchdog_period(watchdog_period), .monitor_reset(monitor_reset), .wake_delay(wake_delay),
  .stop_accept(stop_accept), .illegal_opcode(illegal_opcode));
`default_nettype wire

// ===== testbench/sol_option_latches_bench.sv
// bench for the option latches: four passes of reset, program, probe
// assumes a wait-free slave; expectations queue up for the monitor
`timescale 1ns/1ps
`default_nettype none
`include "sol_params.svh"
module sol_option_latches_bench;
  logic hclk, hresetn, hsel, hwrite, stop_mode, stop_opcode, pin, req, ph_rd, ph_out;
  logic [31:0] haddr, hwdata, x;
  logic [1:0] htrans;
  logic [7:0] va, vb;
  logic [63:0] q[$];
  wire [31:0] hrdata;
  wire [42:0] outs;
  wire hready, hresp;
  int failures, cmp_count;
  sol_option_latches uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .stop_mode(stop_mode), .stop_opcode(stop_opcode), .wake_by_reset_pin(pin),
    .monitor_reset_request(req), .watchdog_enable(outs[42]), .watchdog_period(outs[41:24]),
    .main_supply_monitor_on(outs[23]), .regulator_monitor_on(outs[22]), .monitor_reset(outs[21]),
    .wake_delay(outs[20:8]), .stop_accept(outs[7]), .illegal_opcode(outs[6]), .osc_sleep_run(outs[5:3]),
    .timebase_source_clock(outs[2:1]), .serial_port_clock_select(outs[0]));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  function automatic logic [42:0] eo(input logic [7:0] a, input logic [7:0] b, input logic op);
    logic m;
    m = !stop_mode || a[6];
    return {!a[0], a[7] ? `SOL_WDOG_SHORT : `SOL_WDOG_LONG, !a[4] && m, !a[3] && m, req && !a[5],
      (a[2] && !pin) ? `SOL_WAKE_SHORT : `SOL_WAKE_LONG, op && a[1], op && !a[1], !b[7], b[6:3], b[0]};
  endfunction : eo
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one transfer; for a read, d is the expected word
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ph_rd <= !w;
    if (!w)
      q.push_back(d);
    do @(posedge hclk); while (hready !== 1'b1);
    ph_rd <= 1'b0;
  endtask : bus
  task automatic chk(input logic [42:0] e);
    q.push_back(e);
    ph_out <= 1'b1;
    @(posedge hclk);
    ph_out <= 1'b0;
  endtask : chk
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge hclk)
  begin
    if (ph_rd)
      check(hrdata, q.pop_front());
    if (ph_out)
      check(outs, q.pop_front());
  end
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    repeat (2000) @(posedge hclk);
    failures++;
    give_verdict();
  end
  initial
  begin
    {hresetn, hsel, hwrite, stop_mode, stop_opcode, pin, req, ph_rd, ph_out} = '0;
    {haddr, hwdata, htrans, va, vb} = '0;
    x = 32'h9a4b;
    for (int p = 0; p < 4; p++)
    begin
      hresetn <= 1'b0;
      stop_mode <= p[1];
      pin <= p[0];
      req <= p[1] ^ p[0];
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      va = p[0] ? ~va : 8'(rnd());
      vb = p[0] ? ~vb : 8'(rnd());
      vb[4:3] = p[1:0];
      if (vb[4:3] == `SOL_TB_CRYSTAL)
        va[2] = 1'b0;
      if (stop_mode && (!va[6] || (va[4] && va[3])))
        va[5] = 1'b1;
      bus(1'b0, 32'h74, 32'h0);
      bus(1'b0, 32'h7c, 32'h0);
      chk(eo(8'h0, 8'h0, 1'b0));
      bus(1'b1, 32'h74, {24'h0, va});
      bus(1'b0, 32'h74, {24'h0, va});
      bus(1'b1, 32'h74, {24'h0, ~va});
      bus(1'b0, 32'h80, 32'h1);
      bus(1'b1, 32'h7c, {24'h0, vb});
      bus(1'b1, 32'h80, 32'h0);
      bus(1'b0, 32'h7c, {24'h0, vb & 8'hf9});
      bus(1'b0, 32'h80, 32'h3);
      bus(1'b0, 32'h400, 32'h0);
      repeat (3) @(posedge hclk);
      chk(eo(va, vb, 1'b0));
      stop_opcode <= 1'b1;
      @(posedge hclk);
      stop_opcode <= 1'b0;
      chk(eo(va, vb, 1'b1));
    end
    give_verdict();
  end
endmodule : sol_option_latches_bench
`default_nettype wire
